// ===== include/csi_consts.vh
`ifndef CSI_CONSTS_VH
`define CSI_CONSTS_VH
// Register byte offsets
`define OFS_MODE 8'h00
`define OFS_OPSET 8'h04
`define OFS_DATA 8'h08
`define OFS_STAT 8'h0C
`define OFS_FCLR 8'h10
`define OFS_START 8'h14
`define OFS_STOP 8'h18
`define OFS_ENST 8'h1C
`define OFS_OE 8'h20
`define OFS_LVL 8'h24
`define OFS_PSEL 8'h28
`define OFS_PCE 8'h2C
`define OFS_ISTAT 8'h30
`define OFS_ICLR 8'h34
`define OFS_IEN 8'h38
// Mode register fields
`define MODE_CKS 15
`define MODE_ISEL 0
// Operation setting fields
`define OP_TXE 15
`define OP_RXE 14
`define OP_DAP 13
`define OP_CKP 12
`define OP_LSB 7
`define OP_LEN8 0
// Data register fields
`define DIV_HI 15
`define DIV_LO 9
// Status register fields
`define ST_TSF 6
`define ST_BFF 5
`define ST_OVF 0
// Output level register fields
`define LVL_CK 8
`define LVL_SO 0
// Interrupt bits
`define IRQ_CH 0
`define IRQ_OVR 1
// Reset values, then top bit index per word length
`define RST_MODE 16'h0000
`define RST_OPSET 16'hC081
`define RST_DIV 7'h00
`define RST_LVL 16'h0101
`define RST_PSEL 8'h00
`define MSB7 3'h6
`define MSB8 3'h7
`endif

// ===== src/prescaler_tick.v
`include "csi_consts.vh"

module prescaler_tick (
  // Clock and unit reset
  input wire clk_i,
  input wire rst_i,
  // Selection
  input wire [3:0] sel_a_i,
  input wire [3:0] sel_b_i,
  input wire cks_i,
  // Operation clock enable
  output wire mck_en_o
);
  reg [14:0] cnt_q;
  wire [3:0] sel;
  wire [15:0] mask;

  // Channel picks prescaler output a or b
  assign sel = cks_i ? sel_b_i : sel_a_i;
  assign mask = (16'h0001 << sel) - 16'h0001;
  assign mck_en_o = ((({1'b0, cnt_q}) & mask) == mask);

  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 15'h0000;
    end else begin
      cnt_q <= cnt_q + 15'h0001;
    end
  end
endmodule

// ===== src/serial_shift_engine.v
`include "csi_consts.vh"

module serial_shift_engine (
  // Clock and unit reset
  input wire clk_i,
  input wire rst_i,
  // Control
  input wire run_i,
  input wire mck_en_i,
  input wire [6:0] div_i,
  input wire ckp_i,
  input wire dap_i,
  input wire lsb_i,
  input wire len8_i,
  input wire start_i,
  input wire [7:0] tx_i,
  // Serial data in
  input wire si_i,
  // Results
  output reg busy_o,
  output reg sck_o,
  output reg so_o,
  output reg done_o,
  output reg [7:0] rx_o
);
  reg [6:0] cnt_q;
  reg [7:0] sh_q;
  reg [2:0] idx_q;
  reg ph_q;
  reg pre_q;
  wire idle_lvl;
  wire htick;
  wire [2:0] top;
  wire [2:0] first;
  wire last;
  wire [2:0] nxt;

  assign idle_lvl = ~ckp_i;
  assign htick = mck_en_i && (cnt_q == div_i);
  assign top = len8_i ? `MSB8 : `MSB7;
  assign first = lsb_i ? 3'h0 : top;
  assign last = lsb_i ? (idx_q == top) : (idx_q == 3'h0);
  assign nxt = lsb_i ? idx_q + 3'h1 : idx_q - 3'h1;

  always @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      sck_o <= 1'b1;
      so_o <= 1'b1;
      done_o <= 1'b0;
      rx_o <= 8'h00;
      cnt_q <= 7'h00;
      sh_q <= 8'h00;
      idx_q <= 3'h0;
      ph_q <= 1'b0;
      pre_q <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (mck_en_i) begin
        cnt_q <= htick ? 7'h00 : cnt_q + 7'h01;
      end
      if (!run_i) begin
        busy_o <= 1'b0;
        sck_o <= idle_lvl;
      end else if (start_i && !busy_o) begin
        busy_o <= 1'b1;
        sh_q <= tx_i;
        idx_q <= first;
        ph_q <= 1'b0;
        cnt_q <= 7'h00;
        sck_o <= idle_lvl;
        pre_q <= dap_i;
        if (dap_i) begin
          so_o <= tx_i[first];
        end
      end else if (busy_o && htick) begin
        if (pre_q) begin
          pre_q <= 1'b0;
        end else if (!ph_q) begin
          sck_o <= ~idle_lvl;
          ph_q <= 1'b1;
          if (dap_i) begin
            rx_o[idx_q] <= si_i;
          end else begin
            so_o <= sh_q[idx_q];
          end
        end else begin
          sck_o <= idle_lvl;
          ph_q <= 1'b0;
          if (!dap_i) begin
            rx_o[idx_q] <= si_i;
          end
          if (last) begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
          end else begin
            idx_q <= nxt;
            if (dap_i) begin
              so_o <= sh_q[nxt];
            end
          end
        end
      end else if (!busy_o) begin
        sck_o <= idle_lvl;
      end
    end
  end
endmodule

// ===== src/serial_channel.v
// How it works
// - Writing 1 to stop trigger clears enable status, stopping the channel.
// - Output enable at 0 detaches the data pin from the shift logic.
// - While stopped, the output level register drives clock and data pins.
// - Clearing the peripheral clock enable resets the whole unit.
// - A data write while the buffer is full replaces pending data.
// - Interrupt source select is live; change it before the last bit.
// - Source select 0 gives transfer end, 1 gives buffer empty.
// - Clock select picks prescaler output a (0) or b (1).
// - Master drives the clock, samples data in, flags only overrun.
// - Data phase 1 presents data half a serial clock early.
// - Clock phase 0, data phase 0: output on falling, sample on rising; each 1 swaps.
//
// Chosen here: register access over Wishbone and the address map.
`include "csi_consts.vh"

module serial_channel (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Serial link
  output reg serial_clock_pin_o,
  output reg serial_data_out_pin_o,
  input wire serial_data_in_pin_i,
  // Interrupt
  output reg irq_o
);
  reg pce_q;
  reg [15:0] mode_q;
  reg [15:0] opset_q;
  reg [6:0] div_q;
  reg [15:0] lvl_q;
  reg [7:0] psel_q;
  reg en_q;
  reg oe_q;
  reg [7:0] buf_q;
  reg bff_q;
  reg rx_full_q;
  reg [7:0] rxd_q;
  reg ovf_q;
  reg [1:0] ist_q;
  reg [1:0] ien_q;
  reg [31:0] rd_d;
  wire unit_rst;
  wire req;
  wire wr;
  wire rd;
  wire [15:0] wd;
  wire mck_en;
  wire eng_busy;
  wire eng_sck;
  wire eng_so;
  wire eng_done;
  wire [7:0] eng_rx;
  wire start;
  wire ovr_ev;
  wire ch_ev;
  wire [1:0] iclr;

  // Byte-lane merge of a 16-bit register
  function [15:0] merge;
    input [15:0] old;
    input [15:0] nw;
    input [1:0] sel;
    begin
      merge = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
    end
  endfunction

  // Writes and read side effects land on the edge the master sees ack
  assign req = wb_cyc_i && wb_stb_i;
  assign wr = req && wb_we_i && wb_ack_o;
  assign rd = req && !wb_we_i && wb_ack_o;
  assign wd = wb_dat_i[15:0];

  // Unit held in reset while its clock supply is off
  assign unit_rst = rst_i || !pce_q;

  prescaler_tick u_presc (
    .clk_i(clk_i),
    .rst_i(unit_rst),
    .sel_a_i(psel_q[3:0]),
    .sel_b_i(psel_q[7:4]),
    .cks_i(mode_q[`MODE_CKS]),
    .mck_en_o(mck_en)
  );

  serial_shift_engine u_eng (
    .clk_i(clk_i),
    .rst_i(unit_rst),
    .run_i(en_q),
    .mck_en_i(mck_en),
    .div_i(div_q),
    .ckp_i(opset_q[`OP_CKP]),
    .dap_i(opset_q[`OP_DAP]),
    .lsb_i(opset_q[`OP_LSB]),
    .len8_i(opset_q[`OP_LEN8]),
    .start_i(start),
    .tx_i(buf_q),
    .si_i(serial_data_in_pin_i),
    .busy_o(eng_busy),
    .sck_o(eng_sck),
    .so_o(eng_so),
    .done_o(eng_done),
    .rx_o(eng_rx)
  );

  // Buffer moves to the shifter as soon as the engine is free
  assign start = en_q && bff_q && !eng_busy;
  assign ovr_ev = eng_done && opset_q[`OP_RXE] && rx_full_q;
  // Select read live on every event
  assign ch_ev = mode_q[`MODE_ISEL] ? start : eng_done;
  assign iclr = (wr && wb_adr_i == `OFS_ICLR && wb_sel_i[0]) ?
                wb_dat_i[1:0] : 2'b00;

  always @(posedge clk_i) begin
    if (rst_i) begin
      pce_q <= 1'b0;
    end else if (wr && wb_adr_i == `OFS_PCE && wb_sel_i[0]) begin
      pce_q <= wb_dat_i[0];
    end
  end

  always @(posedge clk_i) begin
    if (unit_rst) begin
      mode_q <= `RST_MODE;
      opset_q <= `RST_OPSET;
      div_q <= `RST_DIV;
      lvl_q <= `RST_LVL;
      psel_q <= `RST_PSEL;
      en_q <= 1'b0;
      oe_q <= 1'b0;
      buf_q <= 8'h00;
      bff_q <= 1'b0;
      rx_full_q <= 1'b0;
      rxd_q <= 8'h00;
      ovf_q <= 1'b0;
      ist_q <= 2'b00;
      ien_q <= 2'b00;
    end else begin
      if (start) begin
        bff_q <= 1'b0;
      end
      if (eng_done && opset_q[`OP_RXE]) begin
        rxd_q <= eng_rx;
        rx_full_q <= 1'b1;
      end else if (rd && wb_adr_i == `OFS_DATA) begin
        rx_full_q <= 1'b0;
      end
      if (wr) begin
        if (wb_adr_i == `OFS_MODE) begin
          mode_q <= merge(mode_q, wd, wb_sel_i[1:0]);
        end else if (wb_adr_i == `OFS_OPSET) begin
          opset_q <= merge(opset_q, wd, wb_sel_i[1:0]);
        end else if (wb_adr_i == `OFS_DATA) begin
          if (wb_sel_i[1]) begin
            div_q <= wd[`DIV_HI:`DIV_LO];
          end
          if (wb_sel_i[0]) begin
            buf_q <= wd[7:0];
            bff_q <= 1'b1;
          end
        end else if (wb_adr_i == `OFS_START) begin
          if (wb_sel_i[0] && wd[0]) begin
            en_q <= 1'b1;
          end
        end else if (wb_adr_i == `OFS_STOP) begin
          if (wb_sel_i[0] && wd[0]) begin
            en_q <= 1'b0;
            bff_q <= 1'b0;
            lvl_q[`LVL_CK] <= eng_sck;
            lvl_q[`LVL_SO] <= eng_so;
          end
        end else if (wb_adr_i == `OFS_OE) begin
          if (wb_sel_i[0]) begin
            oe_q <= wd[0];
          end
        end else if (wb_adr_i == `OFS_LVL) begin
          if (!en_q) begin
            lvl_q <= merge(lvl_q, wd, wb_sel_i[1:0]);
          end
        end else if (wb_adr_i == `OFS_PSEL) begin
          if (wb_sel_i[0]) begin
            psel_q <= wd[7:0];
          end
        end else if (wb_adr_i == `OFS_IEN) begin
          if (wb_sel_i[0]) begin
            ien_q <= wd[1:0];
          end
        end
      end
      if (ovr_ev) begin
        ovf_q <= 1'b1;
      end else if (wr && wb_adr_i == `OFS_FCLR && wb_sel_i[0] && wd[0]) begin
        ovf_q <= 1'b0;
      end
      // New events win over a clear in the same cycle
      ist_q[`IRQ_CH] <= ch_ev | (ist_q[`IRQ_CH] & ~iclr[`IRQ_CH]);
      ist_q[`IRQ_OVR] <= ovr_ev | (ist_q[`IRQ_OVR] & ~iclr[`IRQ_OVR]);
    end
  end

  // Read mux
  always @* begin
    rd_d = 32'h0000_0000;
    if (wb_adr_i == `OFS_MODE) begin
      rd_d[15:0] = mode_q;
    end else if (wb_adr_i == `OFS_OPSET) begin
      rd_d[15:0] = opset_q;
    end else if (wb_adr_i == `OFS_DATA) begin
      rd_d[`DIV_HI:`DIV_LO] = div_q;
      rd_d[7:0] = rxd_q;
    end else if (wb_adr_i == `OFS_STAT) begin
      // Busy shows until shifter and buffer drain
      rd_d[`ST_TSF] = eng_busy | bff_q;
      rd_d[`ST_BFF] = bff_q;
      rd_d[`ST_OVF] = ovf_q;
    end else if (wb_adr_i == `OFS_ENST) begin
      rd_d[0] = en_q;
    end else if (wb_adr_i == `OFS_OE) begin
      rd_d[0] = oe_q;
    end else if (wb_adr_i == `OFS_LVL) begin
      rd_d[15:0] = lvl_q;
    end else if (wb_adr_i == `OFS_PSEL) begin
      rd_d[7:0] = psel_q;
    end else if (wb_adr_i == `OFS_PCE) begin
      rd_d[0] = pce_q;
    end else if (wb_adr_i == `OFS_ISTAT) begin
      rd_d[1:0] = ist_q;
    end else if (wb_adr_i == `OFS_IEN) begin
      rd_d[1:0] = ien_q;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
      wb_dat_o <= (req && !wb_ack_o && !wb_we_i) ? rd_d : 32'h0000_0000;
    end
  end

  // Pins: the level register owns them while stopped
  always @(posedge clk_i) begin
    if (unit_rst) begin
      serial_clock_pin_o <= 1'b1;
      serial_data_out_pin_o <= 1'b1;
      irq_o <= 1'b0;
    end else begin
      serial_clock_pin_o <= en_q ? eng_sck : lvl_q[`LVL_CK];
      // Data pin detached when output disabled
      serial_data_out_pin_o <= (en_q && oe_q && opset_q[`OP_TXE]) ?
                               eng_so : lvl_q[`LVL_SO];
      irq_o <= |(ist_q & ien_q);
    end
  end
endmodule

// ===== test/serial_channel_monitor.sv
`include "csi_consts.vh"

module serial_channel_monitor (
  // Clock and reset
  input logic clk_i,
  input logic rst_i,
  // Bus
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [7:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_i,
  input logic [31:0] wb_dat_o,
  input logic wb_ack_o,
  // Link and interrupt
  input logic serial_clock_pin_o,
  input logic serial_data_out_pin_o,
  input logic serial_data_in_pin_i,
  input logic irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wr;
  logic en_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  assign wr = wb_ack_o && wb_we_i && wb_sel_i[0];
  // Started and not stopped since
  always_ff @(posedge clk_i) begin
    if (rst_i || (wr && wb_adr_i == `OFS_STOP && wb_dat_i[0])) begin
      en_q <= 1'b0;
    end else if (wr && wb_adr_i == `OFS_START && wb_dat_i[0]) begin
      en_q <= 1'b1;
    end
  end
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_stop;
    wr && wb_adr_i == `OFS_STOP && wb_dat_i[0];
  endsequence
  sequence s_lvl;
    wr && !en_q && wb_adr_i == `OFS_LVL;
  endsequence
  chk_ack_req: assert property (s_req |=> wb_ack_o)
    else $error("request not answered");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than a cycle");
  chk_ack_cause: assert property ($rose(wb_ack_o) |->
    $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  chk_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read bits set");
  chk_stop_freeze: assert property (
    s_stop |=> ##1 $stable(serial_clock_pin_o)[*4])
    else $error("clock moves after stop");
  chk_level_drive: assert property (
    s_lvl |=> ##1 serial_clock_pin_o == $past(wb_dat_i[`LVL_CK], 2)
    && serial_data_out_pin_o == $past(wb_dat_i[`LVL_SO], 2))
    else $error("pins do not follow level write");
  chk_irq_off: assert property (
    (wr && wb_adr_i == `OFS_IEN && wb_dat_i[1:0] == 2'h0) |=> ##1 !irq_o)
    else $error("masked interrupt still high");
  chk_reset_idle: assert property (disable iff (1'b0)
    rst_i |=> serial_clock_pin_o && serial_data_out_pin_o && !irq_o
    && !wb_ack_o && wb_dat_o == 32'h0000_0000)
    else $error("outputs not idle after reset");
endmodule

// ===== test/serial_slave_model.sv
module serial_slave_model (
  // Serial link
  input logic sck_i,
  input logic so_i,
  output logic si_o,
  // Setup from the bench
  input logic ckp_i,
  input logic arm_i,
  input logic [7:0] reply_i,
  // Last word seen on the data line
  output logic [7:0] got_o,
  output int count_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  logic [7:0] sh;
  initial begin
    si_o = 1'b0;
    count_o = 0;
  end
  always @(sck_i) begin
    if (!arm_i) begin
      n = 0;
    end else if (sck_i ^ ckp_i) begin
      sh = {sh[6:0], so_i};
      n++;
      if (n == 8) begin
        n = 0;
        got_o = sh;
        count_o++;
        // No pull on this line, so show a fresh level once released
        si_o = ~si_o;
      end
    end else begin
      si_o = reply_i[3'h7 - n[2:0]];
    end
  end
endmodule

// ===== test/serial_channel_tb.sv
`include "csi_consts.vh"

module serial_channel_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic ckp = 1'b0;
  logic arm = 1'b0;
  logic [7:0] rep = 8'h00;
  logic [31:0] r = 32'h0000_63c1;
  logic [31:0] rdat, q;
  logic [63:0] e;
  logic [7:0] got;
  logic ack, sck, sdo, sdi, irq;
  int cnt;
  int fails = 0;
  int comparisons = 0;
  logic [63:0] wq[$];
  logic [7:0] sq[$];

  serial_channel i_serial_channel (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .serial_clock_pin_o(sck), .serial_data_out_pin_o(sdo),
    .serial_data_in_pin_i(sdi), .irq_o(irq));
  serial_slave_model i_serial_slave_model (.sck_i(sck), .so_i(sdo),
    .si_o(sdi), .ckp_i(ckp), .arm_i(arm), .reply_i(rep), .got_o(got),
    .count_o(cnt));

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  // Bit order swap for the LSB-first passes
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++)
      rev[i] = v[7 - i];
  endfunction

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task complete_run;
    if (fails == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'h3);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic [31:0] m);
    wq.push_back({m, x});
    bus(1'b0, a, 32'h0000_0000, 4'h3);
  endtask

  // Polls until the channel is quiet, bounded
  task automatic idle;
    for (int k = 0; k < 300; k++) begin
      bus(1'b0, `OFS_STAT, 32'h0000_0000, 4'h3);
      if (q[`ST_TSF] === 1'b0) break;
    end
    repeat (2) @(posedge clk_i);
  endtask

  always @(posedge clk_i) begin
    if (ack === 1'b1 && !we && wq.size() > 0) begin
      e = wq.pop_front();
      check(rdat & e[63:32], e[31:0]);
    end
  end

  always @(cnt) begin
    check({24'h0, got}, {24'h0, sq.size() > 0 ? sq.pop_front() : 8'hxx});
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    complete_run;
  end

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wr(`OFS_PCE, 32'h0000_0001);
    rd(`OFS_OPSET, 32'h0000_C081, 32'h0000_FFFF);
    rd(8'hFC, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(`OFS_START, 32'h0000_0000, 32'hFFFF_FFFF);
    wr(`OFS_LVL, 32'h0000_0000);
    repeat (2) @(posedge clk_i);
    check({30'h0, sck, sdo}, 32'h0000_0000);
    for (int c = 0; c < 3; c++) begin
      ckp <= (c == 1);
      wr(`OFS_LVL, (c == 1) ? 32'h0000_0001 : 32'h0000_0101);
      // Middle pass MSB first, the others keep the LSB-first reset order
      wr(`OFS_OPSET, (c == 1) ? 32'h0000_D001 : 32'h0000_C081);
      wr(`OFS_OE, (c == 2) ? 32'h0000_0000 : 32'h0000_0001);
      // Divider lane only, so no word is queued before the start
      bus(1'b1, `OFS_DATA, 32'h0000_0600, 4'h2);
      wr(`OFS_IEN, 32'h0000_0003);
      wr(`OFS_START, 32'h0000_0001);
      arm <= 1'b1;
      r = lfsr(r);
      rep <= r[15:8];
      sq.push_back((c == 2) ? 8'hFF : (c == 1) ? r[7:0] : rev(r[7:0]));
      bus(1'b1, `OFS_DATA, {24'h0, r[7:0]}, 4'h1);
      idle;
      check({31'h0, irq}, 32'h0000_0001);
      rd(`OFS_DATA, {24'h0, (c == 1) ? r[15:8] : rev(r[15:8])},
         32'h0000_00FF);
      wr(`OFS_ICLR, 32'h0000_0003);
      repeat (2) @(posedge clk_i);
      check({31'h0, irq}, 32'h0000_0000);
      wr(`OFS_STOP, 32'h0000_0001);
      arm <= 1'b0;
      rd(`OFS_ENST, 32'h0000_0000, 32'h0000_0001);
    end
    wr(`OFS_MODE, 32'h0000_0001);
    wr(`OFS_OE, 32'h0000_0001);
    wr(`OFS_START, 32'h0000_0001);
    arm <= 1'b1;
    sq.push_back(8'h5A);
    sq.push_back(8'hC3);
    bus(1'b1, `OFS_DATA, 32'h0000_005A, 4'h1);
    bus(1'b1, `OFS_DATA, 32'h0000_0011, 4'h1);
    rd(`OFS_STAT, 32'h0000_0060, 32'h0000_0060);
    rd(`OFS_ISTAT, 32'h0000_0001, 32'h0000_0001);
    bus(1'b1, `OFS_DATA, 32'h0000_00C3, 4'h1);
    idle;
    rd(`OFS_STAT, 32'h0000_0001, 32'h0000_0001);
    wr(`OFS_IEN, 32'h0000_0000);
    repeat (2) @(posedge clk_i);
    check({31'h0, irq}, 32'h0000_0000);
    wr(`OFS_STOP, 32'h0000_0001);
    arm <= 1'b0;
    wr(`OFS_PCE, 32'h0000_0000);
    wr(`OFS_PCE, 32'h0000_0001);
    rd(`OFS_MODE, 32'h0000_0000, 32'h0000_FFFF);
    repeat (4) @(posedge clk_i);
    complete_run;
  end
endmodule

bind serial_channel serial_channel_monitor i_serial_channel_monitor (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .serial_clock_pin_o(serial_clock_pin_o),
  .serial_data_out_pin_o(serial_data_out_pin_o),
  .serial_data_in_pin_i(serial_data_in_pin_i), .irq_o(irq_o));
